/* File: ditd_decoder.sv */
// How it works
// - Function 41 input selects motor parameter set
// - Both inactive motor one; first only motor two
// - Terminal PID source: function 43 picks gain set
// - Functions 44/45 raise distinct user faults
// - Function 46 swaps speed/torque mode immediately
// - Function 47 fastest stop, current at limit
// - Function 48 decelerated stop using ramp four
// - Function 49 decelerates then enters DC brake
// - Function 50 clears current run timer
// - Function 51 swaps two-wire and three-wire families
// - Function 52 inhibits reverse like config parameter
// - Four segment bits index sixteen stored settings
// - Full-scale segment maps to max output frequency
// - Segment value also feeds PID or V/F
// - Two ramp bits select ramp sets one-four

// Terminal decoder overview
// Each pin carries an eight-bit function code
// Pins are active high
// Pins pass two flops before any decode
// Config inputs come from the same clock, used directly
// Every request leaves a flop, so outputs never glitch
// A pin change reaches the outputs on the third edge
// A config change reaches the outputs on the next edge
// Several pins with one code are ORed together
// Codes outside the handled set match nothing
// Reserved code 42 has no decode term at all
// Fixed latency, so the core may count on it
// Requests are plain levels, no pulses to miss
// No request is stored past one cycle,
// except the phase of the DC brake sequence
module ditd_decoder
   import ditd_pkg::*;
#(
   parameter int N_TERM = 7,
   parameter int FREQ_W = 16
)
(
   // Clock and reset
   input  wire logic                          ref_clk,
   input  wire logic                          sys_rst,
   // Terminal pins and their function codes
   input  wire logic [N_TERM-1:0]             term_pin,
   input  wire logic [N_TERM-1:0][7:0]        term_func,
   // Configuration
   input  wire logic [1:0]                    pid_gain_switch_source,
   input  wire logic                          speed_torque_mode_cfg,
   input  wire logic [1:0]                    terminal_command_mode,
   input  wire logic                          reverse_prohibit_cfg,
   input  wire logic [FREQ_W-1:0]             max_output_frequency,
   input  wire logic [DITD_SEG_COUNT-1:0][DITD_SEG_W-1:0] segment_setting_table,
   input  wire logic                          dcb_start_reached,
   // Requests and status
   output ditd_req_s                          req,
   output logic [7:0]                         user_fault_code,
   output logic [3:0]                         segment_index,
   output logic [DITD_SEG_W-1:0]              segment_value,
   output logic [FREQ_W-1:0]                  segment_freq
);

   // Elaboration checks
   // Pin count bounded to keep the decode loop short
   // Frequency width bounded by the scale product width
   if (N_TERM < 1 || N_TERM > 32)
   begin : g_chk_term
      $error("N_TERM out of range");
   end
   if (FREQ_W < 1 || FREQ_W > 32)
   begin : g_chk_freq
      $error("FREQ_W out of range");
   end

   // Two-flop synchronisers for the pins
   // Pins are asynchronous contacts or PLC outputs
   // Only the second stage feeds decode; the first may be metastable
   // Reset flushes both stages, so no false request follows reset
   // Two cycles of latency, small next to contact filtering
   // Synchronous reset, like every flop here
   logic [N_TERM-1:0] sync1_r;      // First stage, read only by second
   logic [N_TERM-1:0] pin_r;        // Stable terminal state

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         sync1_r <= '0;
         pin_r   <= '0;
      end
      else
      begin
         sync1_r <= term_pin;
         pin_r   <= sync1_r;
      end
   end

   // Any input with this code active; reserved codes match nothing
   // One loop serves every request code
   // A pin with a code not handled here simply drops out
   // Loop bound is the pin count, not a code range
   function automatic logic func_active(input logic [N_TERM-1:0] st,
                                        input logic [N_TERM-1:0][7:0] fn,
                                        input logic [7:0] code);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < N_TERM; i++)
      begin
         if (fn[i] == code && st[i])
         begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction : func_active

   // Per-code decode of the synchronised terminals
   // One strobe per handled code
   // Built from the synchronised state only
   // Function codes are trusted to be steady config
   // A code change takes effect on the next edge
   // Decoding stays combinational; the output flops absorb it
   wire act_seg0  = func_active(pin_r, term_func, DITD_FN_SEG_B0);
   wire act_seg1  = func_active(pin_r, term_func, DITD_FN_SEG_B1);
   wire act_seg2  = func_active(pin_r, term_func, DITD_FN_SEG_B2);
   wire act_seg3  = func_active(pin_r, term_func, DITD_FN_SEG_B3);
   wire act_ramp0 = func_active(pin_r, term_func, DITD_FN_RAMP_B0);
   wire act_ramp1 = func_active(pin_r, term_func, DITD_FN_RAMP_B1);
   wire act_mot1  = func_active(pin_r, term_func, DITD_FN_MOTOR_SEL1);
   wire act_pid   = func_active(pin_r, term_func, DITD_FN_PID_SW);
   wire act_uf1   = func_active(pin_r, term_func, DITD_FN_USER_F1);
   wire act_uf2   = func_active(pin_r, term_func, DITD_FN_USER_F2);
   wire act_swap  = func_active(pin_r, term_func, DITD_FN_MODE_SWAP);
   wire act_estop = func_active(pin_r, term_func, DITD_FN_ESTOP);
   wire act_dstop = func_active(pin_r, term_func, DITD_FN_DECEL_STOP);
   wire act_dcb   = func_active(pin_r, term_func, DITD_FN_DECEL_DCB);
   wire act_rclr  = func_active(pin_r, term_func, DITD_FN_RUNTIME_CLR);
   wire act_wire  = func_active(pin_r, term_func, DITD_FN_WIRE_SWAP);
   wire act_rev   = func_active(pin_r, term_func, DITD_FN_REV_INHIBIT);

   // Segment index, bit 3 most significant
   // Index picks one of sixteen stored settings
   // Missing segment pins read as zero, so index 0 is the default
   // Bits from different pins may land on different edges;
   // the outside holds them steady so no skewed pick survives
   wire [3:0] seg_idx_w = {act_seg3, act_seg2, act_seg1, act_seg0};
   wire [DITD_SEG_W-1:0] seg_val_w = segment_setting_table[seg_idx_w];

   // Proportional scale: full scale lands on max frequency
   // Stored settings count in tenths of a percent
   // Product is wide enough for full scale times max frequency
   // Division by a constant, folded into logic by synthesis
   // Settings above full scale saturate at max frequency
   // Truncation rounds down, so the result never tops max
   // This divider is the longest path of the block; a slower
   // clock or a pipelined scale would be the fix if timing fails
   wire [DITD_SEG_W+FREQ_W-1:0] seg_prod_w = seg_val_w * max_output_frequency;
   wire [DITD_SEG_W+FREQ_W-1:0] seg_quot_w = seg_prod_w / DITD_SEG_FULL;
   wire [FREQ_W-1:0] seg_freq_w = (seg_val_w >= DITD_SEG_FULL) ? max_output_frequency
                                  : seg_quot_w[FREQ_W-1:0];

   // Ramp index from terminals; forced to set four by function 48
   // Terminal ramp bits pick sets one to four
   // The stop override applies under every command source
   wire [1:0] ramp_term_w = {act_ramp1, act_ramp0};
   wire [1:0] ramp_w      = act_dstop ? DITD_RAMP_SET_FOUR : ramp_term_w;

   // PID gain set only under terminal source
   // Other source settings keep the primary set
   // Gain set follows the terminal level, no latching
   wire pid_sec_w = (pid_gain_switch_source == DITD_PID_SRC_TERM) && act_pid;

   // Mode swap applies in any run state
   // XOR with the configured mode gives the other mode
   // No run-state gating; the core applies it at once
   wire torque_w = speed_torque_mode_cfg ^ act_swap;

   // Wire family swap keeps the type, flips the family bit
   // Bit one selects the family, bit zero the type
   // Two-wire type one becomes three-wire type one and back,
   // type two likewise
   wire [1:0] cmd_mode_w = act_wire ? (terminal_command_mode ^ DITD_WIRE_FAMILY)
                                    : terminal_command_mode;

   // User fault code; fault one reported first when both stand
   // Both faults stay visible in the request struct
   // The code output shows one at a time
   // Zero means no user fault
   // A shared code field keeps the core's fault path simple
   wire [7:0] fault_w = act_uf1 ? DITD_FAULT_USER1
                      : act_uf2 ? DITD_FAULT_USER2 : DITD_FAULT_NONE;

   // Decelerated DC brake sequencer
   // Three phases: idle, decelerating, braking
   // Decelerate until the core reports the start frequency
   // Braking holds while the terminal stands
   // Dropping the terminal returns to idle from any phase
   // Start-frequency flag is same-clock, so no sync here
   // Request bits come from the next phase, so they line up
   // with the other requests on the same edge
   ditd_dcb_e dcb_r;     // Current phase
   ditd_dcb_e dcb_nxt;   // Next phase

   always_comb
   begin
      case (dcb_r)
         DITD_DCB_IDLE:
            // Start with deceleration
            if (act_dcb)
            begin
               dcb_nxt = DITD_DCB_DECEL;
            end
            else
            begin
               dcb_nxt = DITD_DCB_IDLE;
            end
         DITD_DCB_DECEL:
            // Brake once start frequency is reached
            if (!act_dcb)
            begin
               dcb_nxt = DITD_DCB_IDLE;
            end
            else
            begin
               dcb_nxt = dcb_start_reached ? DITD_DCB_BRAKE : DITD_DCB_DECEL;
            end
         DITD_DCB_BRAKE:
            // Hold braking while the terminal stands
            if (act_dcb)
            begin
               dcb_nxt = DITD_DCB_BRAKE;
            end
            else
            begin
               dcb_nxt = DITD_DCB_IDLE;
            end
         default:
            // Upset code, recover to idle
            dcb_nxt = DITD_DCB_IDLE;
      endcase
   end

   // Request assembly
   // Zero default keeps every field defined on every path
   // Emergency stop also pins current at its limit
   // Reverse inhibit is the config bit or the terminal
   // Phase requests taken from the next phase
   ditd_req_s req_nxt;

   always_comb
   begin
      req_nxt                       = '0;
      req_nxt.motor_set_two         = act_mot1;
      req_nxt.pid_gain_secondary    = pid_sec_w;
      req_nxt.user_fault_one        = act_uf1;
      req_nxt.user_fault_two        = act_uf2;
      req_nxt.torque_mode           = torque_w;
      req_nxt.emergency_stop        = act_estop;
      req_nxt.current_at_limit      = act_estop;
      req_nxt.decel_stop            = act_dstop;
      req_nxt.ramp_set              = ramp_w;
      req_nxt.dcb_decel             = (dcb_nxt == DITD_DCB_DECEL);
      req_nxt.dcb_brake             = (dcb_nxt == DITD_DCB_BRAKE);
      req_nxt.runtime_clear         = act_rclr;
      req_nxt.terminal_command_mode = cmd_mode_w;
      req_nxt.reverse_inhibit       = reverse_prohibit_cfg | act_rev;
   end

   // Output registers; inputs are treated as steady past filtering
   // Every output leaves a flop
   // Reset drives all requests inactive and the phase to idle
   // Outputs trail the decode by one edge
   // Config reaches outputs one edge after it changes
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         dcb_r           <= DITD_DCB_IDLE;
         req             <= '0;
         user_fault_code <= DITD_FAULT_NONE;
         segment_index   <= DITD_RST_SEG_IDX;
         segment_value   <= '0;
         segment_freq    <= '0;
      end
      else
      begin
         dcb_r           <= dcb_nxt;
         req             <= req_nxt;
         user_fault_code <= fault_w;
         segment_index   <= seg_idx_w;
         segment_value   <= seg_val_w;
         segment_freq    <= seg_freq_w;
      end
   end

   // Limits
   // No terminal filtering here; contacts or the core provide it
   // Run sequences of two-wire and three-wire modes live in the core
   // Only one motor-select terminal is decoded
   // The segment table is read live; a change shows on the next edge
   // Code 42 and codes other than 12..17 below 41 are ignored

endmodule : ditd_decoder

/* File: ditd_pkg.sv */
package ditd_pkg;

   // Terminal function codes, all handled here except DITD_FN_MOTOR_SEL2 (42)
   localparam logic [7:0] DITD_FN_SEG_B0      = 8'h0c;
   localparam logic [7:0] DITD_FN_SEG_B1      = 8'h0d;
   localparam logic [7:0] DITD_FN_SEG_B2      = 8'h0e;
   localparam logic [7:0] DITD_FN_SEG_B3      = 8'h0f;
   localparam logic [7:0] DITD_FN_RAMP_B0     = 8'h10;
   localparam logic [7:0] DITD_FN_RAMP_B1     = 8'h11;
   localparam logic [7:0] DITD_FN_MOTOR_SEL1  = 8'h29;
   localparam logic [7:0] DITD_FN_MOTOR_SEL2  = 8'h2a;
   localparam logic [7:0] DITD_FN_PID_SW      = 8'h2b;
   localparam logic [7:0] DITD_FN_USER_F1     = 8'h2c;
   localparam logic [7:0] DITD_FN_USER_F2     = 8'h2d;
   localparam logic [7:0] DITD_FN_MODE_SWAP   = 8'h2e;
   localparam logic [7:0] DITD_FN_ESTOP       = 8'h2f;
   localparam logic [7:0] DITD_FN_DECEL_STOP  = 8'h30;
   localparam logic [7:0] DITD_FN_DECEL_DCB   = 8'h31;
   localparam logic [7:0] DITD_FN_RUNTIME_CLR = 8'h32;
   localparam logic [7:0] DITD_FN_WIRE_SWAP   = 8'h33;
   localparam logic [7:0] DITD_FN_REV_INHIBIT = 8'h34;

   // Configuration encodings
   localparam logic [1:0] DITD_PID_SRC_TERM   = 2'h1;
   localparam logic [1:0] DITD_RAMP_SET_FOUR  = 2'h3;
   localparam logic [1:0] DITD_WIRE_FAMILY    = 2'h2;
   localparam int         DITD_SEG_COUNT      = 16;
   localparam int         DITD_SEG_W          = 16;
   localparam logic [15:0] DITD_SEG_FULL      = 16'h03e8;
   localparam logic [7:0] DITD_FAULT_NONE     = 8'h00;
   localparam logic [7:0] DITD_FAULT_USER1    = 8'h01;
   localparam logic [7:0] DITD_FAULT_USER2    = 8'h02;

   // Reset values
   localparam logic [1:0] DITD_RST_TWO_BIT    = 2'h0;
   localparam logic [3:0] DITD_RST_SEG_IDX    = 4'h0;

   // Stop phase states, one-hot
   typedef enum logic [2:0]
   {
      DITD_DCB_IDLE  = 3'b001,
      DITD_DCB_DECEL = 3'b010,
      DITD_DCB_BRAKE = 3'b100
   } ditd_dcb_e;

   // Requests toward the drive core
   typedef struct packed
   {
      logic       motor_set_two;
      logic       pid_gain_secondary;
      logic       user_fault_one;
      logic       user_fault_two;
      logic       torque_mode;
      logic       emergency_stop;
      logic       current_at_limit;
      logic       decel_stop;
      logic [1:0] ramp_set;
      logic       dcb_decel;
      logic       dcb_brake;
      logic       runtime_clear;
      logic [1:0] terminal_command_mode;
      logic       reverse_inhibit;
   } ditd_req_s;

endpackage : ditd_pkg

/* File: ditd_term_drv.sv */
module ditd_term_drv
(
   // Clock
   input  wire logic       ref_clk,
   // Wanted contact levels and the pins
   input  wire logic [6:0] want,
   output logic [6:0]      term_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   // Contacts change only at an edge and then hold, so selection bits never skew
   always_ff @(posedge ref_clk)
      term_pin <= want;
endmodule : ditd_term_drv

/* File: ditd_decoder_props.sv */
module ditd_decoder_chk
   import ditd_pkg::*;
#(
   parameter int N_TERM = 7,
   parameter int FREQ_W = 16
)
(
   // Clock and reset
   input wire logic                          ref_clk,
   input wire logic                          sys_rst,
   // Terminals and configuration
   input wire logic [N_TERM-1:0]             term_pin,
   input wire logic [N_TERM-1:0][7:0]        term_func,
   input wire logic [1:0]                    pid_gain_switch_source,
   input wire logic                          speed_torque_mode_cfg,
   input wire logic [1:0]                    terminal_command_mode,
   input wire logic                          reverse_prohibit_cfg,
   input wire logic [FREQ_W-1:0]             max_output_frequency,
   input wire logic [DITD_SEG_COUNT-1:0][DITD_SEG_W-1:0] segment_setting_table,
   input wire logic                          dcb_start_reached,
   // Outputs watched
   input wire ditd_req_s                     req,
   input wire logic [7:0]                    user_fault_code,
   input wire logic [3:0]                    segment_index,
   input wire logic [DITD_SEG_W-1:0]         segment_value,
   input wire logic [FREQ_W-1:0]             segment_freq
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [N_TERM-1:0]      p1_r, p2_r, p3_r;  // Pin history, matches sync depth plus output flop
   logic [N_TERM-1:0][7:0] f1_r;              // Codes as the design used them
   logic [2:0]             st_r;              // Edges since reset
   // Pin and code history line up with the design's own pipeline
   always_ff @(posedge ref_clk)
   begin
      p1_r <= term_pin;
      p2_r <= p1_r;
      p3_r <= p2_r;
      f1_r <= term_func;
      if (sys_rst)
         st_r <= 3'h0;
      else if (st_r != 3'h4)
         st_r <= st_r + 3'h1;
   end
   // Any terminal with this code active; arguments keep the values sampled
   function automatic logic h(input logic [N_TERM-1:0]      p,
                              input logic [N_TERM-1:0][7:0] fn,
                              input logic [7:0]             c);
      h = 1'b0;
      for (int i = 0; i < N_TERM; i++)
         h |= p[i] && (fn[i] == c);
   endfunction : h
   wire x_estop = h(p3_r, f1_r, DITD_FN_ESTOP);
   wire x_uf1   = h(p3_r, f1_r, DITD_FN_USER_F1);
   wire x_uf2   = h(p3_r, f1_r, DITD_FN_USER_F2);
   wire x_swap  = h(p3_r, f1_r, DITD_FN_MODE_SWAP);
   wire x_dstop = h(p3_r, f1_r, DITD_FN_DECEL_STOP);
   wire x_r1    = h(p3_r, f1_r, DITD_FN_RAMP_B1);
   wire x_r0    = h(p3_r, f1_r, DITD_FN_RAMP_B0);
   wire x_s3    = h(p3_r, f1_r, DITD_FN_SEG_B3);
   wire x_s2    = h(p3_r, f1_r, DITD_FN_SEG_B2);
   wire x_s1    = h(p3_r, f1_r, DITD_FN_SEG_B1);
   wire x_s0    = h(p3_r, f1_r, DITD_FN_SEG_B0);
   wire x_rev   = h(p3_r, f1_r, DITD_FN_REV_INHIBIT);
   wire x_wire  = h(p3_r, f1_r, DITD_FN_WIRE_SWAP);
   wire x_mot   = h(p3_r, f1_r, DITD_FN_MOTOR_SEL1);
   wire ok = (st_r == 3'h4);  // Settled window
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   a_estop_follow: assert property (ok |-> req.emergency_stop == x_estop
      && req.current_at_limit == x_estop) else $error("estop request wrong");
   a_user_fault: assert property (ok |-> user_fault_code == (x_uf1 ? 8'h01
      : x_uf2 ? 8'h02 : 8'h00)) else $error("user fault code wrong");
   a_mode_swap: assert property (ok |-> req.torque_mode ==
      ($past(speed_torque_mode_cfg) ^ x_swap)) else $error("torque mode wrong");
   a_ramp_select: assert property (ok |-> req.ramp_set == (x_dstop ? 2'h3
      : {x_r1, x_r0})) else $error("ramp set wrong");
   a_seg_index: assert property (ok |-> segment_index == {x_s3,
      x_s2, x_s1, x_s0}) else $error("segment index wrong");
   a_rev_inhibit: assert property (ok |-> req.reverse_inhibit ==
      ($past(reverse_prohibit_cfg) | x_rev)) else $error("reverse inhibit wrong");
   a_wire_swap: assert property (ok |-> req.terminal_command_mode ==
      ($past(terminal_command_mode) ^ {x_wire, 1'b0})) else $error("wire mode wrong");
   a_motor_set: assert property (ok |-> req.motor_set_two == x_mot)
      else $error("motor set wrong");
   a_reset_clear: assert property ($fell(sys_rst) |-> req == '0 && segment_index == 4'h0)
      else $error("outputs not cleared by reset");
endmodule : ditd_decoder_chk
bind ditd_decoder ditd_decoder_chk #(.N_TERM(N_TERM), .FREQ_W(FREQ_W)) i_ditd_decoder_chk (.*);

/* File: tb.sv */
module tb
   import ditd_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 1'b0, sys_rst = 1'b1, dcb = 1'b0, stm = 1'b0, rpc = 1'b0;
   logic [6:0]        want = '0, term_pin;   // Wanted levels, pins
   logic [6:0][7:0]   term_func = '0;        // Function codes
   logic [1:0]        pid_src = '0, tcm = '0; // Configuration
   logic [15:0]       maxf = 16'h1388;       // Max output frequency
   logic [15:0][15:0] tbl;                   // Segment settings
   ditd_req_s         req;
   logic [7:0]        ufc;
   logic [3:0]        sidx, ix;
   logic [15:0]       sval, sfreq;
   logic [31:0]       f;
   int miscompares = 0, n_checks = 0, seed = 32'h82aa, r;
   always #2.5 ref_clk = ~ref_clk;
   ditd_term_drv i_ditd_term_drv (.ref_clk(ref_clk), .want(want), .term_pin(term_pin));
   ditd_decoder i_ditd_decoder (.ref_clk(ref_clk), .sys_rst(sys_rst), .term_pin(term_pin),
      .term_func(term_func), .pid_gain_switch_source(pid_src), .speed_torque_mode_cfg(stm),
      .terminal_command_mode(tcm), .reverse_prohibit_cfg(rpc), .max_output_frequency(maxf),
      .segment_setting_table(tbl), .dcb_start_reached(dcb), .req(req), .user_fault_code(ufc),
      .segment_index(sidx), .segment_value(sval), .segment_freq(sfreq));
   // One comparison
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task report_and_stop;
      if (miscompares == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : report_and_stop
   // Any pin carrying this code is active
   function automatic logic hit(input logic [7:0] c);
      hit = 1'b0;
      for (int i = 0; i < 7; i++)
         hit |= term_pin[i] && (term_func[i] == c);
   endfunction : hit
   // Hang guard, run needs about 10 us
   initial
   begin
      #50us;
      miscompares++;
      report_and_stop();
   end
   initial
   begin
      for (int i = 0; i < 16; i++)
         tbl[i] = 16'($unsigned($random(seed)) % 1001);  // Settings up to full scale
      tbl[0] = 16'h0000;  // Zero and full scale corners
      tbl[15] = 16'h03e8;
      tbl[14] = 16'hffff;  // Above full scale saturates
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      // Random codes, levels and configuration
      repeat (200)
      begin
         @(posedge ref_clk);
         for (int i = 0; i < 7; i++)
         begin
            r = $unsigned($random(seed)) % 18;
            term_func[i] <= (r < 6) ? 8'(8'h0c + r) : 8'(8'h23 + r);
         end
         want <= 7'($random(seed));
         {stm, pid_src, tcm, rpc} <= 6'($random(seed));
         repeat (8) @(posedge ref_clk);
         ix = {hit(8'h0f), hit(8'h0e), hit(8'h0d), hit(8'h0c)};
         f = tbl[ix] * maxf / 1000;
         f = (f > maxf) ? 32'(maxf) : f;
         chk(32'(sidx), 32'(ix));
         chk(32'(sval), 32'(tbl[ix]));
         chk(32'(sfreq), f);
         chk(32'(ufc), hit(8'h2c) ? 1 : hit(8'h2d) ? 2 : 0);
         chk(32'(req.ramp_set), hit(8'h30) ? 3 : {hit(8'h11), hit(8'h10)});
         chk(32'(req.decel_stop), 32'(hit(8'h30)));
         chk(32'(req.torque_mode), 32'(stm ^ hit(8'h2e)));
         chk(32'(req.pid_gain_secondary), 32'(pid_src == 2'h1 && hit(8'h2b)));
         chk(32'(req.runtime_clear), 32'(hit(8'h32)));
         chk(32'(req.motor_set_two), 32'(hit(8'h29)));
         chk(32'(req.emergency_stop), 32'(hit(8'h2f)));
         chk(32'(req.current_at_limit), 32'(hit(8'h2f)));
         chk(32'({req.user_fault_one, req.user_fault_two}), 32'({hit(8'h2c), hit(8'h2d)}));
         chk(32'(req.terminal_command_mode), hit(8'h33) ? 32'(2'(tcm + 2'h2)) : 32'(tcm));
         chk(32'(req.reverse_inhibit), 32'(rpc | hit(8'h34)));
         chk(32'({req.dcb_decel, req.dcb_brake}), hit(8'h31) ? 2 : 0);
      end
      // Reserved code on every pin does nothing
      {stm, pid_src, tcm, rpc} <= '0;
      term_func <= {7{8'h2a}};
      want <= '1;
      repeat (8) @(posedge ref_clk);
      chk(32'(req), 0);
      // Decelerate, then brake once start frequency reached
      term_func[0] <= 8'h31;
      repeat (6) @(posedge ref_clk);
      chk(32'({req.dcb_decel, req.dcb_brake}), 2);
      dcb <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk(32'({req.dcb_decel, req.dcb_brake}), 1);
      want <= '0;
      repeat (6) @(posedge ref_clk);
      chk(32'({req.dcb_decel, req.dcb_brake}), 0);
      // Reset in mid-run with stop active
      term_func[0] <= 8'h2f;
      want <= '1;
      repeat (6) @(posedge ref_clk);
      chk(32'(req.emergency_stop), 1);
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk(32'(req), 0);
      // Release again: synchronisers start flushed
      sys_rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk(32'(req), 0);
      repeat (2) @(posedge ref_clk);
      chk(32'(req.emergency_stop), 1);
      report_and_stop();
   end
endmodule : tb
